/* File: rtl/lms_pkg.sv */
package lms_pkg;
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] LMS_ADDR_ENABLES   = 8'h08;
  localparam logic [7:0] LMS_ADDR_BOOST_OUT = 8'h0D;
  localparam logic [7:0] LMS_ADDR_FREQ      = 8'h0E;
  localparam logic [7:0] LMS_ADDR_SW_RESET  = 8'h60;
  localparam logic [7:0] LMS_ADDR_CONTROL   = 8'h0A;
  // Field positions
  localparam int LMS_BIT_STANDBY_REL = 6;
  localparam int LMS_BIT_BOOST_RUN   = 5;
  localparam int LMS_BIT_AUTOLOAD    = 0;
  // Reset values
  localparam logic [7:0] LMS_RST_ENABLES   = 8'h00;
  localparam logic [7:0] LMS_RST_BOOST_OUT = 8'h3F;
  localparam logic [7:0] LMS_RST_FREQ      = 8'h07;
  localparam logic [7:0] LMS_RST_CONTROL   = 8'h01;
  // Timing
  localparam int LMS_CLK_MHZ          = 100;
  localparam int LMS_STARTUP_MS       = 10;
  localparam int LMS_SOFTSTART_MS     = 10;
  localparam int LMS_STARTUP_CYCLES   =
    LMS_STARTUP_MS * 1000 * 1000 * LMS_CLK_MHZ / 1000;
  localparam int LMS_SOFTSTART_CYCLES =
    LMS_SOFTSTART_MS * 1000 * 1000 * LMS_CLK_MHZ / 1000;
  localparam int LMS_MIN_PULSE_NS     = 25;
  localparam int LMS_MIN_PULSE_CYCLES =
    (LMS_MIN_PULSE_NS * LMS_CLK_MHZ + 999) / 1000;
  // Switching period in clock cycles for 2.00, 1.67, 1.00 MHz
  localparam int LMS_PERIOD_FAST = 50;
  localparam int LMS_PERIOD_MID  = 60;
  localparam int LMS_PERIOD_SLOW = 100;
  localparam int LMS_PERIOD_W    = 8;

  typedef enum logic [4:0] {
    LMS_ST_RESET    = 5'b00001,
    LMS_ST_STANDBY  = 5'b00010,
    LMS_ST_STARTUP  = 5'b00100,
    LMS_ST_BOOST_SS = 5'b01000,
    LMS_ST_NORMAL   = 5'b10000
  } lms_state_t;

  // Thermometer code to level 0..8
  function automatic logic [3:0] lms_level(input logic [7:0] code);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      if (code[i])
        n = 4'(i + 1);
    return n;
  endfunction
endpackage

/* File: rtl/lms_delay_timer.sv */
`timescale 1ns/100ps
module lms_delay_timer
  import lms_pkg::*;
#(
  parameter int COUNT = 1000000
)
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Control
  input  wire logic run,
  output logic      done
);
  localparam int W = $clog2(COUNT + 1);
  // Elaboration check: a zero count would raise done at once, with no delay
  if (COUNT < 1)
    $error("COUNT must be at least 1");
  logic [W-1:0] count;

  // Count while run is high; dropping run restarts the delay
  always_ff @(posedge clock)
  begin
    if (!rstn || !run)
      count <= '0;
    else if (count != W'(COUNT))
      count <= count + W'(1);
  end

  assign done = run && (count == W'(COUNT));
endmodule

/* File: rtl/lms_switch_gen.sv */
`timescale 1ns/100ps
module lms_switch_gen
  import lms_pkg::*;
#(
  parameter int MIN_PULSE = 3
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Control
  input  wire logic       enable,
  input  wire logic [2:0] freq_sel,
  // Switch drive
  output logic            sw_pulse
);
  // Elaboration check: the pulse must fit inside the shortest period
  if (MIN_PULSE < 1 || MIN_PULSE >= LMS_PERIOD_FAST)
    $error("MIN_PULSE out of range");
  logic [LMS_PERIOD_W-1:0] phase;
  logic [LMS_PERIOD_W-1:0] period;

  // Decode rate: top bit fastest, 01x middle, 00x slowest
  always_comb
  begin
    if (freq_sel[2])
      period = LMS_PERIOD_W'(LMS_PERIOD_FAST);
    else if (freq_sel[1])
      period = LMS_PERIOD_W'(LMS_PERIOD_MID);
    else
      period = LMS_PERIOD_W'(LMS_PERIOD_SLOW);
  end

  // Phase counter of the switching period, from the system oscillator
  always_ff @(posedge clock)
  begin
    if (!rstn || !enable)
      phase <= '0;
    else if (phase >= period - LMS_PERIOD_W'(1))
      phase <= '0;
    else
      phase <= phase + LMS_PERIOD_W'(1);
  end

  // A minimum pulse every period, never skipped even at no load
  always_ff @(posedge clock)
  begin
    if (!rstn)
      sw_pulse <= 1'b0;
    else
      sw_pulse <= enable && (phase < LMS_PERIOD_W'(MIN_PULSE));
  end
endmodule

/* File: rtl/lms_mode_seq.sv */
`timescale 1ns/100ps
module lms_mode_seq
  import lms_pkg::*;
#(
  parameter int STARTUP_CYCLES   = LMS_STARTUP_CYCLES,
  parameter int SOFTSTART_CYCLES = LMS_SOFTSTART_CYCLES
)
(
  // Clock and resets
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       external_reset_n,
  input  wire logic       por_active,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Status inputs
  input  wire logic       thermal_shutdown,
  input  wire logic       light_load,
  // Analog block controls
  output logic            blocks_on,
  output logic            boost_pfm,
  output logic            boost_pwm,
  output logic            sw_pulse,
  output logic            active_load_on,
  output logic            led_force_off,
  output logic [3:0]      vout_level,
  output logic [2:0]      freq_sel,
  output lms_state_t      mode
);
  // ***************************************************
  // Reset generation
  // ***************************************************
  // Elaboration check: a zero delay would leave its state after one cycle
  if (STARTUP_CYCLES < 1 || SOFTSTART_CYCLES < 1)
    $error("delay counts must be at least 1");

  logic       sw_reset;
  logic       int_rstn;
  logic [7:0] enables;
  logic [7:0] boost_out;
  logic [7:0] freq_reg;
  logic [7:0] control;
  logic       startup_done;
  logic       ss_done;
  logic       boost_run_q;
  lms_state_t next_mode;

  // Soft reset is registered for one cycle so the write itself completes
  always_ff @(posedge clock)
  begin
    if (!rstn)
      sw_reset <= 1'b0;
    else
      sw_reset <= reg_wr && (reg_addr == LMS_ADDR_SW_RESET);
  end

  // Any reset source holds the whole block in reset
  assign int_rstn = rstn && external_reset_n && !por_active
                    && !sw_reset;

  // ***************************************************
  // Control registers
  // ***************************************************
  // Writes accepted in every mode, any bits, any order
  always_ff @(posedge clock)
  begin
    if (!int_rstn)
    begin
      enables   <= LMS_RST_ENABLES;
      boost_out <= LMS_RST_BOOST_OUT;
      freq_reg  <= LMS_RST_FREQ;
      control   <= LMS_RST_CONTROL;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        LMS_ADDR_ENABLES:   enables   <= reg_wdata;
        LMS_ADDR_BOOST_OUT: boost_out <= reg_wdata;
        LMS_ADDR_FREQ:      freq_reg  <= reg_wdata;
        LMS_ADDR_CONTROL:   control   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Readback; the reset register is write only and reads zero
  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        LMS_ADDR_ENABLES:   reg_rdata = enables;
        LMS_ADDR_BOOST_OUT: reg_rdata = boost_out;
        LMS_ADDR_FREQ:      reg_rdata = freq_reg;
        LMS_ADDR_CONTROL:   reg_rdata = {3'h0, mode};
        default:            reg_rdata = 8'h00;
      endcase
    end
  end

  wire standby_release_bit = enables[LMS_BIT_STANDBY_REL];
  wire boost_run           = enables[LMS_BIT_BOOST_RUN];

  // Edge of the boost-run bit, for entry from normal mode
  always_ff @(posedge clock)
  begin
    if (!int_rstn)
      boost_run_q <= 1'b0;
    else
      boost_run_q <= boost_run;
  end

  // ***************************************************
  // Mode state machine
  // ***************************************************
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      LMS_ST_RESET:    next_mode = LMS_ST_STANDBY;
      LMS_ST_STANDBY:
        if (standby_release_bit)
          next_mode = LMS_ST_STARTUP;
      LMS_ST_STARTUP:
        if (!standby_release_bit)
          next_mode = LMS_ST_STANDBY;
        else if (startup_done && !thermal_shutdown)
          next_mode = boost_run ? LMS_ST_BOOST_SS
                                : LMS_ST_NORMAL;
      LMS_ST_BOOST_SS:
        if (!standby_release_bit)
          next_mode = LMS_ST_STANDBY;
        else if (thermal_shutdown)
          next_mode = LMS_ST_STARTUP;
        else if (!boost_run)
          next_mode = LMS_ST_NORMAL;
        else if (ss_done)
          next_mode = LMS_ST_NORMAL;
      LMS_ST_NORMAL:
        if (!standby_release_bit)
          next_mode = LMS_ST_STANDBY;
        else if (thermal_shutdown)
          next_mode = LMS_ST_STARTUP;
        else if (boost_run && !boost_run_q)
          next_mode = LMS_ST_BOOST_SS;
      default:         next_mode = LMS_ST_RESET;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!int_rstn)
      mode <= LMS_ST_RESET;
    else
      mode <= next_mode;
  end

  // ***************************************************
  // Delay timers and switch generation
  // ***************************************************
  // Delays count oscillator cycles and restart on each entry
  lms_delay_timer #(.COUNT(STARTUP_CYCLES)) u_startup_timer
  (
    .clock (clock),
    .rstn  (int_rstn),
    .run   (mode == LMS_ST_STARTUP),
    .done  (startup_done)
  );

  lms_delay_timer #(.COUNT(SOFTSTART_CYCLES)) u_softstart_timer
  (
    .clock (clock),
    .rstn  (int_rstn),
    .run   (mode == LMS_ST_BOOST_SS),
    .done  (ss_done)
  );

  // Switching clock comes from the same oscillator as all timing
  lms_switch_gen #(.MIN_PULSE(LMS_MIN_PULSE_CYCLES)) u_switch
  (
    .clock    (clock),
    .rstn     (int_rstn),
    .enable   (boost_pwm),
    .freq_sel (freq_sel),
    .sw_pulse (sw_pulse)
  );

  // ***************************************************
  // Outputs
  // ***************************************************
  // Registered controls; standby keeps everything off for low power
  always_ff @(posedge clock)
  begin
    if (!int_rstn)
    begin
      blocks_on      <= 1'b0;
      boost_pfm      <= 1'b0;
      boost_pwm      <= 1'b0;
      active_load_on <= 1'b0;
      led_force_off  <= 1'b1;
      vout_level     <= lms_level(LMS_RST_BOOST_OUT);
      freq_sel       <= LMS_RST_FREQ[2:0];
    end
    else
    begin
      blocks_on  <= next_mode != LMS_ST_STANDBY &&
                    next_mode != LMS_ST_RESET;
      boost_pfm  <= next_mode == LMS_ST_BOOST_SS;
      boost_pwm  <= next_mode == LMS_ST_NORMAL && boost_run;
      // Active load only while boosting and enabled
      active_load_on <= control[LMS_BIT_AUTOLOAD] && light_load
                        && next_mode == LMS_ST_NORMAL && boost_run;
      // LEDs dark outside normal mode, incl. soft start
      led_force_off <= next_mode != LMS_ST_NORMAL;
      vout_level    <= lms_level(boost_out);
      freq_sel      <= freq_reg[2:0];
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence s_enter_ss;
    mode != LMS_ST_BOOST_SS ##1 mode == LMS_ST_BOOST_SS;
  endsequence

  AST_RESET_MODE: assert property (@(posedge clock)
    !int_rstn |=> mode == LMS_ST_RESET)
    else $error("mode not reset");
  AST_RESET_TO_STANDBY: assert property (@(posedge clock)
    disable iff (!int_rstn) mode == LMS_ST_RESET |=> mode == LMS_ST_STANDBY)
    else $error("reset did not go to standby");
  AST_SWRESET: assert property (@(posedge clock) disable iff (!rstn)
    reg_wr && reg_addr == LMS_ADDR_SW_RESET |=> ##1 mode == LMS_ST_RESET)
    else $error("soft reset missed");
  AST_STANDBY_OFF: assert property (@(posedge clock)
    disable iff (!int_rstn)
    mode == LMS_ST_STANDBY |-> !blocks_on && !boost_pwm && !boost_pfm)
    else $error("blocks on in standby");
  AST_LED_OFF_SS: assert property (@(posedge clock)
    disable iff (!int_rstn) mode == LMS_ST_BOOST_SS |-> led_force_off)
    else $error("leds on during soft start");
  AST_TSD_STARTUP: assert property (@(posedge clock)
    disable iff (!int_rstn)
    mode == LMS_ST_NORMAL && thermal_shutdown && standby_release_bit
    |=> mode == LMS_ST_STARTUP)
    else $error("thermal shutdown ignored");
  // Soft start may end early only on thermal, standby or a cleared run bit
  sequence s_ss_quiet;
    (boost_run && standby_release_bit && !thermal_shutdown) [*7];
  endsequence

  // Only meaningful when soft start lasts at least eight cycles
  if (SOFTSTART_CYCLES >= 7)
  begin : g_ss_len
    AST_SS_LEN: assert property (@(posedge clock)
      disable iff (!int_rstn)
      s_enter_ss ##0 s_ss_quiet |=> mode == LMS_ST_BOOST_SS)
      else $error("soft start too short");
  end
  AST_BOOST_ENTRY: assert property (@(posedge clock)
    disable iff (!int_rstn)
    mode == LMS_ST_NORMAL && boost_run && !boost_run_q
    && standby_release_bit && !thermal_shutdown
    |=> mode == LMS_ST_BOOST_SS)
    else $error("boost start missed");
  AST_STANDBY_HOLD: assert property (@(posedge clock)
    disable iff (!int_rstn)
    mode == LMS_ST_STANDBY && !standby_release_bit
    |=> mode == LMS_ST_STANDBY)
    else $error("left standby with release bit clear");
  AST_LEVEL_MAX: assert property (@(posedge clock)
    disable iff (!int_rstn) vout_level <= 4'h8)
    else $error("output level out of range");
  AST_BOOST_HALT: assert property (@(posedge clock)
    disable iff (!int_rstn) !boost_run |=> !boost_pwm)
    else $error("boost not halted");
  AST_AUTOLOAD: assert property (@(posedge clock)
    disable iff (!int_rstn) !control[LMS_BIT_AUTOLOAD] |=> !active_load_on)
    else $error("active load on while disabled");
  AST_FREQ_RST: assert property (@(posedge clock)
    !int_rstn |=> freq_sel == LMS_RST_FREQ[2:0] && !blocks_on)
    else $error("frequency select reset wrong");
endmodule

/* File: test/lms_host_model.sv */
`timescale 1ns/100ps
// ******************************
// Host driving the register port
// ******************************
module lms_host_model
  import lms_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Register port
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Quiet bus at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hFF;
    reg_wdata = 8'h00;
  end

  // One-cycle strobe; idle lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read data is taken at the edge that ends the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    d = reg_rdata;
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask

  // Stop the converter once the load is gone, to save current
  task automatic stop_boost(input logic [7:0] en);
    wr(LMS_ADDR_ENABLES, en & 8'hDF);
  endtask
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
// ******************************
// Mode sequencer bench
// ******************************
module testbench;
  import lms_pkg::*;
  // Short delays keep the run small
  localparam int SU = 20;
  localparam int SS = 20;
  localparam logic [7:0] FC [3] = '{8'h01, 8'h03, 8'h07};
  localparam int         PE [3] = '{100, 60, 50};
  logic       clock            = 1'b0;
  logic       rstn             = 1'b0;
  logic       external_reset_n = 1'b1;
  logic       por_active       = 1'b0;
  logic       thermal_shutdown = 1'b0;
  logic       light_load       = 1'b0;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       blocks_on;
  logic       boost_pfm;
  logic       boost_pwm;
  logic       sw_pulse;
  logic       active_load_on;
  logic       led_force_off;
  logic [3:0] vout_level;
  logic [2:0] freq_sel;
  lms_state_t mode;
  logic [7:0] rv;
  logic       all;
  int         err_count = 0;
  int         tests_run = 0;
  int         n;
  int         p;
  int         w;

  // 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  lms_host_model host_u (.clock(clock), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  lms_mode_seq #(.STARTUP_CYCLES(SU), .SOFTSTART_CYCLES(SS)) dut_u (
    .clock(clock), .rstn(rstn), .external_reset_n(external_reset_n),
    .por_active(por_active), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thermal_shutdown(thermal_shutdown), .light_load(light_load),
    .blocks_on(blocks_on), .boost_pfm(boost_pfm), .boost_pwm(boost_pwm),
    .sw_pulse(sw_pulse), .active_load_on(active_load_on),
    .led_force_off(led_force_off), .vout_level(vout_level),
    .freq_sel(freq_sel), .mode(mode));

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rv);
    chk(rv, e);
  endtask

  // Cycles spent in one mode; f tells whether LEDs and PFM held throughout
  task automatic span(input lms_state_t st, output int c, output logic f);
    int k;
    c = 0;
    f = 1'b1;
    for (k = 0; k < 600 && !(c > 0 && mode !== st); k++)
    begin
      @(negedge clock);
      if (mode === st)
      begin
        c++;
        f = f && led_force_off === 1'b1 && boost_pfm === 1'b1;
      end
    end
    if (k == 600)
    begin
      chk(0, 1);
      summarize();
    end
  endtask

  // Rise-to-rise period and high width of one switch pulse
  task automatic per(output int pd, output int hw);
    int k;
    int s;
    logic pv;
    pd = 0;
    hw = 0;
    s  = 0;
    pv = 1'b1;
    for (k = 0; k < 400 && s < 2; k++)
    begin
      @(negedge clock);
      if (sw_pulse === 1'b1 && pv === 1'b0)
        s++;
      if (s == 1)
      begin
        pd++;
        if (sw_pulse === 1'b1)
          hw++;
      end
      pv = sw_pulse;
    end
    if (s < 2)
    begin
      chk(0, 1);
      summarize();
    end
  endtask

  // Hang guard
  initial
  begin
    #500000;
    err_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(negedge clock);
    chk(mode, LMS_ST_STANDBY);
    chk(blocks_on, 1'b0);
    rdchk(LMS_ADDR_ENABLES, 8'h00);
    rdchk(LMS_ADDR_BOOST_OUT, 8'h3F);
    rdchk(LMS_ADDR_FREQ, 8'h07);
    chk(freq_sel, 3'h7);
    rdchk(8'h33, 8'h00);
    rdchk(LMS_ADDR_SW_RESET, 8'h00);
    // Writes land in standby, used later at power up
    host_u.wr(LMS_ADDR_BOOST_OUT, 8'h0F);
    host_u.wr(LMS_ADDR_FREQ, 8'h01);
    rdchk(LMS_ADDR_BOOST_OUT, 8'h0F);
    chk(mode, LMS_ST_STANDBY);
    host_u.wr(LMS_ADDR_ENABLES, 8'h40);
    span(LMS_ST_STARTUP, n, all);
    chk(n, SU + 1);
    chk(mode, LMS_ST_NORMAL);
    chk(blocks_on, 1'b1);
    chk(vout_level, 4'h4);
    chk(boost_pwm, 1'b0);
    host_u.wr(LMS_ADDR_ENABLES, 8'h60);
    span(LMS_ST_BOOST_SS, n, all);
    chk(n, SS + 1);
    chk(all, 1'b1);
    chk(mode, LMS_ST_NORMAL);
    chk(boost_pwm, 1'b1);
    chk(led_force_off, 1'b0);
    // Each rate; first period after a change may be partial
    for (int i = 0; i < 3; i++)
    begin
      host_u.wr(LMS_ADDR_FREQ, FC[i]);
      per(p, w);
      per(p, w);
      chk(p, PE[i]);
      chk(w >= LMS_MIN_PULSE_CYCLES, 1);
    end
    for (int i = 0; i < 9; i++)
    begin
      host_u.wr(LMS_ADDR_BOOST_OUT, 8'((9'h1 << i) - 9'h1));
      repeat (2) @(negedge clock);
      chk(vout_level, i);
    end
    @(posedge clock);
    light_load <= 1'b1;
    repeat (3) @(negedge clock);
    chk(active_load_on, 1'b1);
    host_u.wr(LMS_ADDR_CONTROL, 8'h00);
    repeat (2) @(negedge clock);
    chk(active_load_on, 1'b0);
    @(posedge clock);
    light_load       <= 1'b0;
    thermal_shutdown <= 1'b1;
    repeat (2) @(negedge clock);
    chk(mode, LMS_ST_STARTUP);
    chk(boost_pwm | boost_pfm, 1'b0);
    repeat (40) @(negedge clock);
    chk(mode, LMS_ST_STARTUP);
    @(posedge clock);
    thermal_shutdown <= 1'b0;
    span(LMS_ST_BOOST_SS, n, all);
    chk(n, SS + 1);
    host_u.stop_boost(8'h60);
    repeat (2) @(negedge clock);
    chk(boost_pwm, 1'b0);
    chk(mode, LMS_ST_NORMAL);
    host_u.wr(LMS_ADDR_ENABLES, 8'h00);
    repeat (2) @(negedge clock);
    chk(mode, LMS_ST_STANDBY);
    chk(blocks_on, 1'b0);
    // Pin reset, supply-low reset, then a register-triggered reset
    for (int i = 0; i < 3; i++)
    begin
      host_u.wr(LMS_ADDR_BOOST_OUT, 8'h01);
      if (i < 2)
      begin
        @(posedge clock);
        external_reset_n <= (i != 0);
        por_active       <= (i == 1);
        repeat (3) @(posedge clock);
        external_reset_n <= 1'b1;
        por_active       <= 1'b0;
      end
      else
        host_u.wr(LMS_ADDR_SW_RESET, 8'hA5);
      span(LMS_ST_RESET, n, all);
      chk(n > 0, 1);
      chk(mode, LMS_ST_STANDBY);
      rdchk(LMS_ADDR_BOOST_OUT, 8'h3F);
      rdchk(LMS_ADDR_ENABLES, 8'h00);
    end
    summarize();
  end
endmodule
